// *** hdl/dmc_pkg.sv ***
// Package for the strobe-level controller of a 64K x 4 dynamic RAM
// Assumes a 200 MHz clock; all device timings are turned into cycle counts here
package dmc_pkg;

    // Clock period in picoseconds
    localparam int CLK_PS = 5000;

    // Device timings in their own units, fastest grade
    localparam int POWERUP_US = 200;
    localparam int IDLE_LIMIT_MS = 4;
    localparam int REFRESH_US_X10 = 156;
    localparam int WAKE_CYCLES = 8;
    localparam int ROW_PULSE_NS = 100;
    localparam int COL_PULSE_NS = 50;
    localparam int ROW_PRECHARGE_NS = 80;
    localparam int ROW_TO_COL_MIN_NS = 20;
    localparam int ROW_TO_COL_MAX_NS = 50;
    localparam int ROW_ACCESS_NS = 100;
    localparam int COL_ACCESS_NS = 50;
    localparam int COL_TO_STORE_NS = 85;
    localparam int ROW_TO_STORE_NS = 135;
    localparam int PAGE_CYCLE_NS = 100;
    localparam int PAGE_COL_PRECHARGE_NS = 40;
    localparam int REFRESH_COL_SETUP_NS = 10;
    localparam int REFRESH_COL_HOLD_NS = 30;
    localparam int COUNTER_TEST_PRE_NS = 20;
    localparam int ENABLE_ACCESS_NS = 25;
    localparam int WRITE_HOLD_NS = 30;

    // Least times round up, longest round down, never below one cycle
    function automatic int min_cyc(input int ns);
        int c;
        c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction
    function automatic int max_cyc(input int ns);
        int c;
        c = (ns * 1000) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    // Cycle counts
    localparam int POWERUP_CYC = POWERUP_US * 1000 * 1000 / CLK_PS;
    localparam int IDLE_LIMIT_CYC = IDLE_LIMIT_MS * 1000 * (1000 * 1000 / CLK_PS);
    localparam int REFRESH_CYC = REFRESH_US_X10 * 100 * 1000 / CLK_PS;
    localparam int ROW_PULSE_CYC = min_cyc(ROW_PULSE_NS);
    localparam int COL_PULSE_CYC = min_cyc(COL_PULSE_NS);
    localparam int ROW_PRE_CYC = min_cyc(ROW_PRECHARGE_NS);
    localparam int RCD_CYC = min_cyc(ROW_TO_COL_MIN_NS);
    localparam int RCD_MAX_CYC = max_cyc(ROW_TO_COL_MAX_NS);
    localparam int ROW_ACC_CYC = min_cyc(ROW_ACCESS_NS);
    localparam int COL_ACC_CYC = min_cyc(COL_ACCESS_NS);
    localparam int CWD_CYC = min_cyc(COL_TO_STORE_NS);
    localparam int RWD_CYC = min_cyc(ROW_TO_STORE_NS);
    localparam int PAGE_CYC = min_cyc(PAGE_CYCLE_NS);
    localparam int PAGE_PRE_CYC = min_cyc(PAGE_COL_PRECHARGE_NS);
    localparam int CSR_CYC = min_cyc(REFRESH_COL_SETUP_NS);
    localparam int CHR_CYC = min_cyc(REFRESH_COL_HOLD_NS);
    localparam int CPT_CYC = min_cyc(COUNTER_TEST_PRE_NS);
    localparam int GA_CYC = min_cyc(ENABLE_ACCESS_NS);
    localparam int WH_CYC = min_cyc(WRITE_HOLD_NS);

    // Field widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 4;
    localparam int CNT_W = 24;

    // Request opcodes
    typedef enum logic [1:0] {
        DMC_OP_READ = 2'h0,
        DMC_OP_WRITE = 2'h1,
        DMC_OP_RMW = 2'h2,
        DMC_OP_TEST = 2'h3
    } dmc_op_t;

    // User request
    typedef struct packed {
        dmc_op_t op;
        logic [ADDR_W-1:0] row;
        logic [ADDR_W-1:0] col;
        logic [DATA_W-1:0] wdata;
        logic page;
    } dmc_req_t;

    // Strobe pins toward the RAM
    typedef struct packed {
        logic row_strobe_n;
        logic col_strobe_n;
        logic write_n;
        logic out_en_n;
        logic [ADDR_W-1:0] multiplexed_address;
    } dmc_pins_t;

endpackage

// *** hdl/dmc_sync.sv ***
// Three-flop input synchroniser for a bus of pin inputs
// Assumes inputs arrive from outside the clk domain
`timescale 1ns/1ps
`default_nettype none
module dmc_sync #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Raw pins and filtered value
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    // Three sampling stages
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // Shift chain; first stage read only by the second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Per bit, accept a change once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    dout[i] <= 1'b0;
                end else if (s2[i] == s3[i]) begin
                    dout[i] <= s3[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// *** hdl/dmc_ctrl.sv ***
// Controller that drives a 64K x 4 dynamic RAM through its strobe pins
// Assumes a 200 MHz clk, synchronous rst_n and a RAM on the pins below
`timescale 1ns/1ps
`default_nettype none
module dmc_ctrl #(
    parameter int POWERUP_CYC = dmc_pkg::POWERUP_CYC,
    parameter int IDLE_LIMIT_CYC = dmc_pkg::IDLE_LIMIT_CYC,
    parameter int REFRESH_CYC = dmc_pkg::REFRESH_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // User request
    input wire logic req_valid,
    input wire dmc_pkg::dmc_req_t req,
    output logic req_ready,
    // User answer
    output logic rsp_valid,
    output logic [dmc_pkg::DATA_W-1:0] rsp_data,
    output logic init_done,
    // RAM pins
    output dmc_pkg::dmc_pins_t pins,
    output logic [dmc_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe_n,
    input wire logic [dmc_pkg::DATA_W-1:0] dq_in
);
    ////////////////////////////////////////////////////////////////////////////
    // States
    typedef enum logic [3:0] {
        ST_POWER = 4'h0,
        ST_WAKE = 4'h1,
        ST_IDLE = 4'h2,
        ST_ROW = 4'h3,
        ST_COL = 4'h4,
        ST_STORE = 4'h5,
        ST_COLPRE = 4'h6,
        ST_RPRE = 4'h7,
        ST_RFCOL = 4'h8,
        ST_RFROW = 4'h9,
        ST_TPRE = 4'ha
    } dmc_state_t;

    dmc_state_t state; // Current state
    logic [dmc_pkg::CNT_W-1:0] cnt; // Phase counter
    logic [dmc_pkg::CNT_W-1:0] ras_cnt; // Cycles since row strobe fell
    logic [dmc_pkg::CNT_W-1:0] idle_cnt; // Cycles with no row strobe
    logic [dmc_pkg::CNT_W-1:0] rf_cnt; // Refresh interval timer
    logic [3:0] wake_cnt; // Wake cycles done
    logic rf_due; // Refresh owed
    logic wake_mode; // Cycle is a wake cycle
    logic [dmc_pkg::DATA_W-1:0] dq_s; // Synchronised data pins
    dmc_pkg::dmc_req_t cur; // Request in service

    // Data pins pass the synchroniser
    dmc_sync #(.W(dmc_pkg::DATA_W)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din(dq_in),
        .dout(dq_s)
    );

    // Constant width helper
    function automatic logic [dmc_pkg::CNT_W-1:0] c(input int v);
        return dmc_pkg::CNT_W'(v);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Refresh timer: owe one row every interval
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rf_cnt <= '0;
            rf_due <= 1'b0;
        end else begin
            if (rf_cnt >= c(REFRESH_CYC - 1)) begin
                rf_cnt <= '0;
                rf_due <= 1'b1;
            end else begin
                rf_cnt <= rf_cnt + 1'b1;
                if (state == ST_RFROW && cnt == '0) begin
                    rf_due <= 1'b0;
                end
            end
        end
    end

    // Idle watch: row strobe silence too long forces wake cycles
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            idle_cnt <= '0;
        end else if (!pins.row_strobe_n) begin
            idle_cnt <= '0;
        end else if (idle_cnt != c(IDLE_LIMIT_CYC)) begin
            idle_cnt <= idle_cnt + 1'b1;
        end
    end

    // Row-active time counter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ras_cnt <= '0;
        end else if (pins.row_strobe_n) begin
            ras_cnt <= '0;
        end else begin
            ras_cnt <= ras_cnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequencer; one timing set for all cycles
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= ST_POWER;
            cnt <= '0;
            wake_cnt <= '0;
            wake_mode <= 1'b0;
            init_done <= 1'b0;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= '0;
            cur <= '0;
            pins <= '{1'b1, 1'b1, 1'b1, 1'b1, 8'h00};
            dq_out <= '0;
            dq_oe_n <= 1'b1;
        end else begin
            rsp_valid <= 1'b0;
            req_ready <= 1'b0;
            cnt <= cnt + 1'b1;
            unique case (state)
                ST_POWER: begin
                    if (cnt >= c(POWERUP_CYC - 1)) begin
                        state <= ST_WAKE;
                        cnt <= '0;
                        wake_cnt <= '0;
                    end
                end
                ST_WAKE: begin
                    // Row-only wake cycle, row strobe low for a full pulse
                    wake_mode <= 1'b1;
                    pins.row_strobe_n <= 1'b0;
                    state <= ST_ROW;
                    cnt <= '0;
                end
                ST_IDLE: begin
                    if (idle_cnt == c(IDLE_LIMIT_CYC)) begin
                        init_done <= 1'b0;
                        wake_cnt <= '0;
                        state <= ST_WAKE;
                    end else if (rf_due) begin
                        // Column strobe first, counter picks the row
                        pins.col_strobe_n <= 1'b0;
                        cur.op <= dmc_pkg::DMC_OP_READ; // Plain refresh, never a test
                        state <= ST_RFCOL;
                        cnt <= '0;
                    end else if (req_valid) begin
                        req_ready <= 1'b1;
                        cur <= req;
                        pins.multiplexed_address <= req.row;
                        if (req.op == dmc_pkg::DMC_OP_TEST) begin
                            pins.col_strobe_n <= 1'b0;
                            state <= ST_RFCOL;
                        end else begin
                            pins.row_strobe_n <= 1'b0;
                            state <= ST_ROW;
                        end
                        cnt <= '0;
                    end
                end
                ST_RFCOL: begin
                    // Column low ahead of the row strobe
                    if (cnt >= c(dmc_pkg::CSR_CYC - 1)) begin
                        pins.row_strobe_n <= 1'b0;
                        cnt <= '0;
                        state <= ST_RFROW;
                    end
                end
                ST_RFROW: begin
                    // Release column after hold; a test reopens it, a refresh ends
                    if (cnt >= c(dmc_pkg::CHR_CYC - 1)) begin
                        pins.col_strobe_n <= 1'b1;
                    end
                    if (cur.op == dmc_pkg::DMC_OP_TEST
                            && cnt >= c(dmc_pkg::CHR_CYC - 1)) begin
                        state <= ST_TPRE;
                        cnt <= '0;
                    end else if (cnt >= c(dmc_pkg::ROW_PULSE_CYC - 1)) begin
                        pins.row_strobe_n <= 1'b1;
                        state <= ST_RPRE;
                        cnt <= '0;
                    end
                end
                ST_TPRE: begin
                    // Counter test: column high, then low again with the column
                    if (cnt >= c(dmc_pkg::CPT_CYC - 1)) begin
                        pins.col_strobe_n <= 1'b0;
                        pins.multiplexed_address <= cur.col;
                        pins.write_n <= 1'b1;
                        pins.out_en_n <= 1'b0;
                        state <= ST_COL;
                        cnt <= '0;
                    end
                end
                ST_ROW: begin
                    if (wake_mode) begin
                        if (cnt >= c(dmc_pkg::ROW_PULSE_CYC - 1)) begin
                            pins.row_strobe_n <= 1'b1;
                            state <= ST_RPRE;
                            cnt <= '0;
                        end
                    end else if (cnt >= c(dmc_pkg::RCD_CYC - 1)) begin
                        // Column strobe inside the multiplex window
                        pins.multiplexed_address <= cur.col;
                        pins.col_strobe_n <= 1'b0;
                        pins.write_n <= (cur.op != dmc_pkg::DMC_OP_WRITE);
                        pins.out_en_n <= (cur.op == dmc_pkg::DMC_OP_WRITE);
                        if (cur.op == dmc_pkg::DMC_OP_WRITE) begin
                            dq_out <= cur.wdata;
                            dq_oe_n <= 1'b0;
                        end
                        state <= ST_COL;
                        cnt <= '0;
                    end
                end
                ST_COL: begin
                    // Wait the column access plus the pin synchroniser
                    if (cur.op == dmc_pkg::DMC_OP_RMW
                            && cnt >= c(dmc_pkg::CWD_CYC - 1)
                            && ras_cnt >= c(dmc_pkg::RWD_CYC - 1)) begin
                        rsp_data <= dq_s;
                        pins.out_en_n <= 1'b1;
                        dq_out <= cur.wdata;
                        state <= ST_STORE;
                        cnt <= '0;
                    end else if (cur.op != dmc_pkg::DMC_OP_RMW
                            && cnt >= c(dmc_pkg::COL_PULSE_CYC + 4)
                            && ras_cnt >= c(dmc_pkg::ROW_ACC_CYC + 4)) begin
                        rsp_data <= dq_s;
                        rsp_valid <= 1'b1;
                        pins.col_strobe_n <= 1'b1;
                        pins.out_en_n <= 1'b1;
                        pins.write_n <= 1'b1;
                        dq_oe_n <= 1'b1;
                        state <= ST_COLPRE;
                        cnt <= '0;
                    end
                end
                ST_STORE: begin
                    // Late write after output turned off
                    if (cnt == c(dmc_pkg::GA_CYC)) begin
                        dq_oe_n <= 1'b0;
                        pins.write_n <= 1'b0;
                    end
                    if (cnt >= c(dmc_pkg::GA_CYC + dmc_pkg::WH_CYC)) begin
                        rsp_valid <= 1'b1;
                        pins.col_strobe_n <= 1'b1;
                        pins.write_n <= 1'b1;
                        dq_oe_n <= 1'b1;
                        state <= ST_COLPRE;
                        cnt <= '0;
                    end
                end
                ST_COLPRE: begin
                    // Page mode keeps row low and recycles column
                    if (cnt >= c(dmc_pkg::PAGE_PRE_CYC - 1)
                            && ras_cnt >= c(dmc_pkg::ROW_PULSE_CYC)) begin
                        if (cur.page && req_valid && !rf_due && req.page
                                && req.row == cur.row
                                && req.op != dmc_pkg::DMC_OP_TEST) begin
                            req_ready <= 1'b1;
                            cur <= req;
                            pins.multiplexed_address <= req.col;
                            pins.col_strobe_n <= 1'b0;
                            pins.write_n <= (req.op != dmc_pkg::DMC_OP_WRITE);
                            pins.out_en_n <= (req.op == dmc_pkg::DMC_OP_WRITE);
                            dq_out <= req.wdata;
                            dq_oe_n <= (req.op != dmc_pkg::DMC_OP_WRITE);
                            state <= ST_COL;
                        end else begin
                            pins.row_strobe_n <= 1'b1;
                            state <= ST_RPRE;
                        end
                        cnt <= '0;
                    end
                end
                ST_RPRE: begin
                    // Row precharge before the next row strobe
                    if (cnt >= c(dmc_pkg::ROW_PRE_CYC - 1)) begin
                        cnt <= '0;
                        if (wake_mode && wake_cnt < 4'(dmc_pkg::WAKE_CYCLES - 1)) begin
                            wake_cnt <= wake_cnt + 1'b1;
                            state <= ST_WAKE;
                        end else begin
                            if (wake_mode) begin
                                init_done <= 1'b1;
                            end
                            wake_mode <= 1'b0;
                            state <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    power_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == ST_POWER) |-> pins.row_strobe_n)
        else $error("row strobe during power pause");
    col_window_a: assert property (@(posedge clk) disable iff (!rst_n)
        ($fell(pins.col_strobe_n) && !pins.row_strobe_n && state == ST_COL
            && $past(state) == ST_ROW) |-> ras_cnt <= c(dmc_pkg::RCD_MAX_CYC))
        else $error("column strobe past window");
    row_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(pins.row_strobe_n) |-> !pins.row_strobe_n [*8])
        else $error("row pulse too short");
    row_precharge_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(pins.row_strobe_n) |-> pins.row_strobe_n [*8])
        else $error("row precharge too short");
    read_write_high_a: assert property (@(posedge clk) disable iff (!rst_n)
        ($fell(pins.col_strobe_n) && cur.op == dmc_pkg::DMC_OP_READ) |-> pins.write_n)
        else $error("write low in read");
    page_pre_a: assert property (@(posedge clk) disable iff (!rst_n)
        ($rose(pins.col_strobe_n) && !pins.row_strobe_n && state != ST_TPRE)
            |-> pins.col_strobe_n [*8])
        else $error("page precharge too short");
    counter_pre_a: assert property (@(posedge clk) disable iff (!rst_n)
        ($rose(pins.col_strobe_n) && state == ST_TPRE) |-> pins.col_strobe_n [*4])
        else $error("counter test column precharge short");
    refresh_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        ($fell(pins.row_strobe_n) && !pins.col_strobe_n) |-> !pins.col_strobe_n [*6])
        else $error("refresh column hold short");
    refresh_due_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rf_due) && state == ST_IDLE |-> ##1 (state == ST_RFCOL))
        else $error("refresh not started");
    early_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        ($fell(pins.col_strobe_n) && cur.op == dmc_pkg::DMC_OP_WRITE) |-> !pins.write_n)
        else $error("write late in early write");
    wake_cover: cover property (@(posedge clk) $rose(init_done));
    page_cover: cover property (@(posedge clk)
        $fell(pins.col_strobe_n) && $past(state) == ST_COLPRE);
    refresh_cover: cover property (@(posedge clk) state == ST_RFROW);
    rmw_cover: cover property (@(posedge clk) state == ST_STORE);
endmodule
`default_nettype wire

// *** dv/dmc_ram_model.sv ***
// Behavioural 64K x 4 dynamic RAM on the strobe pins, with timing watch
// Assumes registered strobes; edge spacing measured in ns, faults in viol
`timescale 1ns/1ps
`default_nettype none
module dmc_ram_model (
    // Strobes and write data from the controller
    input wire dmc_pkg::dmc_pins_t pins,
    input wire logic [3:0] dq_wr,
    // Read data toward the controller
    output logic [3:0] dq_rd
);
    logic [3:0] mem [0:65535]; // Cell array
    logic [7:0] row = '0, col = '0, rcnt = '0; // Latched address, refresh row
    logic cbr = 1'b0, ew = 1'b0, rd_on; // Refresh mode, early write, driving
    logic [3:0] last = '0; // Last value driven
    int viol = 0, ras_falls = 0, cas_falls = 0, pages = 0;
    realtime trf = -1.0e6, trr = -1.0e6, tcf = -1.0e6, tcr = -1.0e6;
    ////////////////////////////////////////////////////////////////
    // Row strobe falls: latch row, or refresh from the counter
    always @(negedge pins.row_strobe_n) begin
        if ($realtime - trr < 80.0) viol++;
        ras_falls++;
        cbr = !pins.col_strobe_n;
        if (cbr) begin
            if ($realtime - tcf < 10.0) viol++;
            row = rcnt;
            rcnt = rcnt + 8'h01;
        end else begin
            row = pins.multiplexed_address;
        end
        trf = $realtime;
    end
    // Row strobe rises: pulse width
    always @(posedge pins.row_strobe_n) begin
        if ($realtime - trf < 100.0) viol++;
        trr = $realtime;
    end
    // Column strobe falls: always counted and timed; address latched only while the row is open
    always @(negedge pins.col_strobe_n) begin
        cas_falls++;
        if (!pins.row_strobe_n) begin
            if (cbr) begin
                if ($realtime - tcr < 20.0) viol++;
            end else if (tcf > trf) begin
                pages++;
                if ($realtime - tcf < 100.0 || $realtime - tcr < 40.0) viol++;
            end else if ($realtime - trf < 20.0 || $realtime - trf > 50.0) viol++;
            col = pins.multiplexed_address;
            ew = !pins.write_n;
        end
        tcf = $realtime;
        if (ew && !pins.row_strobe_n) begin
            #1;
            mem[{row, col}] = dq_wr;
        end
    end
    // Column strobe rises: pulse width and refresh hold
    always @(posedge pins.col_strobe_n) begin
        if (!pins.row_strobe_n && !cbr && $realtime - tcf < 50.0) viol++;
        if (!pins.row_strobe_n && cbr && $realtime - trf < 30.0) viol++;
        tcr = $realtime;
    end
    // Late write: must be clear of both read-write delays
    always @(negedge pins.write_n) begin
        if (!pins.col_strobe_n && !pins.row_strobe_n && !ew) begin
            if ($realtime - tcf < 85.0 || $realtime - trf < 135.0) viol++;
            #1;
            mem[{row, col}] = dq_wr;
        end
    end
    ////////////////////////////////////////////////////////////////
    // Output is not latched; released pins show the inverse of the last value
    assign rd_on = !pins.col_strobe_n && !pins.out_en_n && !ew;
    assign dq_rd = rd_on ? mem[{row, col}] : ~last;
    always @(negedge rd_on) last = mem[{row, col}];
endmodule
`default_nettype wire

// *** dv/dmc_ctrl_tb_top.sv ***
// Bench for the strobe controller with the RAM model on its pins
// Assumes dmc_ram_model; power, idle and refresh counts are shortened
`timescale 1ns/1ps
`default_nettype none
module dmc_ctrl_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0;
    dmc_pkg::dmc_req_t req = '0;
    logic req_ready, rsp_valid, init_done, dq_oe_n;
    logic [3:0] rsp_data, dq_out, dq_rd, dq_in, got;
    dmc_pkg::dmc_pins_t pins;
    int fail_count = 0, num_checks = 0, cyc = 0, n;
    logic [7:0] r0;
    always #2.5 clk = ~clk;
    assign dq_in = dq_oe_n ? dq_rd : dq_out; // Wire level from both drivers
    dmc_ctrl #(.POWERUP_CYC(50), .IDLE_LIMIT_CYC(2000), .REFRESH_CYC(200)) dut (
        .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .init_done(init_done), .pins(pins),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));
    dmc_ram_model ram (.pins(pins), .dq_wr(dq_out), .dq_rd(dq_rd));
    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // One request, held until taken, then wait for its answer
    task automatic xfer(input logic [1:0] op, input logic [7:0] r, c,
            input logic [3:0] d, input logic pg);
        int k;
        req_valid <= 1'b1;
        req <= '{dmc_pkg::dmc_op_t'(op), r, c, d, pg};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (req_ready !== 1'b1 && k < 3000);
        req_valid <= 1'b0;
        while (rsp_valid !== 1'b1 && k < 3000) begin
            @(posedge clk);
            k++;
        end
        got = rsp_data;
        check("answer in time", k < 3000, 1);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_init();
        repeat (20) @(posedge clk);
        check("reset pins", pins, 12'hf00);
        rst_n <= 1'b1;
        n = 0;
        while (pins.row_strobe_n !== 1'b0 && n < 500) begin
            @(posedge clk);
            n++;
        end
        check("pause", n >= 50, 1);
        while (init_done !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        check("wake cycles", ram.ras_falls, 8);
        check("wake col", ram.cas_falls, 0);
        $display("init done");
    endtask
    task automatic t_rw();
        for (int i = 0; i < 4; i++) xfer(2'h1, 8'h55 * i, ~(8'h55 * i), 4'h9 ^ i, 1'b0);
        for (int i = 0; i < 4; i++) begin
            xfer(2'h0, 8'h55 * i, ~(8'h55 * i), 4'h0, 1'b0);
            check("read back", got, 4'h9 ^ i);
        end
        xfer(2'h2, 8'haa, 8'h55, 4'h6, 1'b0);
        check("rmw old", got, 4'hb);
        xfer(2'h0, 8'haa, 8'h55, 4'h0, 1'b0);
        check("rmw new", got, 4'h6);
        $display("read write done");
    endtask
    task automatic t_page();
        n = ram.pages;
        xfer(2'h1, 8'h77, 8'h01, 4'ha, 1'b1);
        xfer(2'h1, 8'h77, 8'h02, 4'hb, 1'b1);
        xfer(2'h0, 8'h77, 8'h01, 4'h0, 1'b1);
        check("page rd1", got, 4'ha);
        xfer(2'h0, 8'h77, 8'h02, 4'h0, 1'b0);
        check("page rd2", got, 4'hb);
        check("page used", ram.pages > n, 1);
        $display("page done");
    endtask
    task automatic t_refresh();
        r0 = ram.rcnt;
        repeat (450) @(posedge clk);
        check("refresh rows", 8'(ram.rcnt - r0) >= 8'h02, 1);
        for (int i = 0; i < 256; i++) xfer(2'h1, i[7:0], 8'hc3, i[3:0] ^ 4'h6, 1'b0);
        xfer(2'h3, 8'h00, 8'hc3, 4'h0, 1'b0);
        check("counter test", got, ram.row[3:0] ^ 4'h6);
        check("timing", ram.viol, 0);
        $display("refresh done");
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            wrap_up();
        end
    end
    initial begin
        t_init();
        t_rw();
        t_page();
        t_refresh();
        wrap_up();
    end
endmodule
`default_nettype wire
